// ===== sbfe_core.sv
// Serial port buffer, flag and error logic with its link-side frame shifter
//
// Operation
// R1: Transmit-only mode never sets receive-full or overrun
// R2: Write to empty buffer stores, clears empty
// R3: Buffer moves to free shifter, sets empty, interrupts
// R4: Buffered data waits while shifter is busy
// R5: Frame end, receive buffer free: store, flag, interrupt (code: not while an overrun flag stands)
// R6: Frame end sets empty, reloads pending data
// R7: Overrun frame end still frees the shifter
// R8: Data read returns buffer, clears receive-full
// R9: Software writes on empty interrupt or flag
// R10: Software reads on full interrupt or flag
// R11: Write to full buffer is silently dropped
// R12: Slave frame without data resends last received
// R13: Read when empty returns last value, no error
// R14: Frame end into full buffer: drop, overrun
// R15: Wrong parity in full duplex flags error
// R16: Multi-master select while idle: stop, disable, fault
// R17: Multi-master select mid-frame: abort, disable, fault
// R18: Slave select negated mid-frame: abort, disable, fault (code: only before the first frame end of a select)
// R19: Flags change after configured frame count only
// R20: Clearing enable empties transmit buffer
// R21: Flags stay readable until cleared
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Link-side shifter, cleared between frames by the core
// ------------------------------------------------------------------
module sbfe_link (
   input wire logic link_clk_i,
   input wire logic frame_clr_i,
   input wire logic master_i,
   input wire logic par_en_i,
   input wire logic [sbfe_pkg::WORD_W-1:0] tx_word_i,
   input wire logic mosi_i,
   input wire logic miso_i,
   output sbfe_pkg::sbfe_link_t link_o,
   output logic tx_bit_o
);
   sbfe_pkg::sbfe_lstate_t s_r;
   sbfe_pkg::sbfe_lstate_t s_nxt;
   logic rx_bit;
   logic [sbfe_pkg::CNT_W-1:0] last_cnt;

   // Word, mode and parity inputs are core flops, mode and parity held still for the whole frame,
   // so they are read here without a synchroniser.
   always_comb begin
      s_nxt = s_r;
      rx_bit = master_i ? miso_i : mosi_i;
      last_cnt = par_en_i ? sbfe_pkg::CNT_PARITY : sbfe_pkg::CNT_LAST_DATA;
      if (s_r.cnt == sbfe_pkg::CNT_FIRST) begin
         s_nxt.shreg = {tx_word_i[sbfe_pkg::WORD_W-2:0], rx_bit};
         s_nxt.tx_bit = tx_word_i[sbfe_pkg::WORD_W-1];
         s_nxt.tx_par = ^tx_word_i;
      end else if (s_r.cnt <= sbfe_pkg::CNT_LAST_DATA) begin
         s_nxt.shreg = {s_r.shreg[sbfe_pkg::WORD_W-2:0], rx_bit};
         s_nxt.tx_bit = s_r.shreg[sbfe_pkg::WORD_W-1];
      end else begin
         s_nxt.tx_bit = s_r.tx_par;
         s_nxt.par_bad = rx_bit ^ (^s_r.shreg);
      end
      if (s_r.cnt == last_cnt) begin
         s_nxt.cnt = sbfe_pkg::CNT_FIRST;
         s_nxt.done_tog = ~s_r.done_tog;
         s_nxt.hold = s_nxt.shreg;
         if (!par_en_i) begin
            s_nxt.par_bad = 1'b0;
         end
      end else begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
   end

   // The link clock may stop between frames, so the frame state is cleared
   // asynchronously by the core rather than by a clocked reset.
   always_ff @(posedge link_clk_i or posedge frame_clr_i) begin
      if (frame_clr_i) begin
         s_r <= sbfe_pkg::LINK_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link_o = '{done_tog: s_r.done_tog, par_bad: s_r.par_bad, rx_word: s_r.hold};
   assign tx_bit_o = s_r.tx_bit;

endmodule : sbfe_link

// ------------------------------------------------------------------
// Core-side buffers, flags and error detection
// ------------------------------------------------------------------
module sbfe_core (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic wr_strobe_i,
   input wire logic [sbfe_pkg::WORD_W-1:0] wr_data_i,
   input wire logic rd_strobe_i,
   input wire logic port_enable_bit_i,
   input wire logic tx_only_select_i,
   input wire logic master_mode_i,
   input wire logic multi_master_i,
   input wire logic parity_en_i,
   input wire logic [sbfe_pkg::IDX_W-1:0] frame_count_field_i,
   input wire logic overrun_clr_i,
   input wire logic parity_err_clr_i,
   input wire logic mode_fault_clr_i,
   input wire logic slave_select_in_n_i,
   input wire logic master_out_pin_i,
   input wire logic master_in_pin_i,
   output logic [sbfe_pkg::WORD_W-1:0] rd_data_o,
   output logic tx_empty_flag_o,
   output logic rx_full_flag_o,
   output logic overrun_flag_o,
   output logic parity_err_flag_o,
   output logic mode_fault_flag_o,
   output logic tx_empty_irq_o,
   output logic rx_full_irq_o,
   output logic serial_clock_oe_o,
   output logic master_out_pin_o,
   output logic master_out_oe_o,
   output logic master_in_pin_o,
   output logic master_in_oe_o,
   output logic [sbfe_pkg::SEL_W-1:0] slave_select_outs_n_o,
   output logic slave_select_outs_oe_o
);
   sbfe_pkg::sbfe_cstate_t s_r;
   sbfe_pkg::sbfe_cstate_t s_nxt;
   sbfe_pkg::sbfe_link_t link_w;
   logic tx_bit_w;
   logic active_w;
   logic done_ev_w;
   logic fault_w;
   logic open_w;

   sbfe_link u_link (
      .link_clk_i (link_clk_i),
      .frame_clr_i (s_r.frame_n),
      .master_i (s_r.master),
      .par_en_i (s_r.par_en),
      .tx_word_i (s_r.tx_frame),
      .mosi_i (master_out_pin_i),
      .miso_i (master_in_pin_i),
      .link_o (link_w),
      .tx_bit_o (tx_bit_w)
   );

   assign active_w = port_enable_bit_i && !s_r.modf;
   assign done_ev_w = !s_r.frame_n && (s_r.done_s2 != s_r.done_seen);
   assign fault_w = active_w && ((master_mode_i && multi_master_i && !s_r.ss_s2)   // R16 R17
                    || (!master_mode_i && s_r.mid && s_r.ss_s2 && !done_ev_w));     // R18

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      open_w = 1'b0;
      s_nxt.tx_irq = 1'b0;
      s_nxt.rx_irq = 1'b0;
      s_nxt.ss_s1 = slave_select_in_n_i;
      s_nxt.ss_s2 = s_r.ss_s1;
      s_nxt.done_s1 = link_w.done_tog;
      s_nxt.done_s2 = s_r.done_s1;
      s_nxt.done_seen = s_r.done_s2;
      // Clears first so that a set in the same cycle wins
      if (overrun_clr_i) begin
         s_nxt.ovr = 1'b0;
      end
      if (parity_err_clr_i) begin
         s_nxt.par_err = 1'b0;
      end
      if (mode_fault_clr_i) begin
         s_nxt.modf = 1'b0;
      end
      if (fault_w) begin
         s_nxt.modf = 1'b1;   // R16 R17 R18 R21
      end
      if (wr_strobe_i && active_w && s_r.tx_empty) begin   // R11
         s_nxt.tx_mem[s_r.tx_wr_idx] = wr_data_i;   // R2
         if (s_r.tx_wr_idx == frame_count_field_i) begin   // R19
            s_nxt.tx_empty = 1'b0;   // R2
            s_nxt.tx_wr_idx = '0;
         end else begin
            s_nxt.tx_wr_idx = s_r.tx_wr_idx + 1'b1;
         end
      end
      if (rd_strobe_i) begin
         if (s_r.rx_full) begin
            s_nxt.rd_data = s_r.rx_mem[s_r.rx_rd_idx];   // R8
            if (s_r.rx_rd_idx == frame_count_field_i) begin   // R19
               s_nxt.rx_full = 1'b0;   // R8
               s_nxt.rx_rd_idx = '0;
            end else begin
               s_nxt.rx_rd_idx = s_r.rx_rd_idx + 1'b1;
            end
         end else begin
            s_nxt.rd_data = s_r.last_rx;   // R13
         end
      end
      if (done_ev_w) begin
         // The word is read once its toggle has crossed; it holds until the next frame end or until frame_n clears the link.
         s_nxt.mid = 1'b0;
         if (s_r.in_flight) begin
            s_nxt.shift_full = 1'b0;   // R6 R7
            s_nxt.in_flight = 1'b0;
         end
         // A standing overrun blocks storing; a frame end into a full buffer sets it again over a same-cycle clear
         if (!tx_only_select_i) begin   // R1
            if (s_nxt.rx_full) begin
               s_nxt.ovr = 1'b1;   // R14
            end else if (!s_r.ovr) begin
               s_nxt.rx_mem[s_r.rx_wr_idx] = link_w.rx_word;   // R5
               s_nxt.last_rx = link_w.rx_word;
               if (s_r.par_en && link_w.par_bad) begin
                  s_nxt.par_err = 1'b1;   // R15
               end
               if (s_r.rx_wr_idx == frame_count_field_i) begin   // R19
                  s_nxt.rx_full = 1'b1;   // R5
                  s_nxt.rx_irq = 1'b1;
                  s_nxt.rx_wr_idx = '0;
               end else begin
                  s_nxt.rx_wr_idx = s_r.rx_wr_idx + 1'b1;
               end
            end
         end
      end
      // Move waits one cycle after the last write so the cleared flag is seen
      if (active_w && !s_r.tx_empty && !s_nxt.shift_full) begin   // R3 R4 R6
         s_nxt.tx_frame = s_nxt.tx_mem[s_r.tx_rd_idx];
         s_nxt.shift_full = 1'b1;
         if (s_r.tx_rd_idx == frame_count_field_i) begin   // R19
            s_nxt.tx_empty = 1'b1;   // R3
            s_nxt.tx_irq = 1'b1;
            s_nxt.tx_rd_idx = '0;
         end else begin
            s_nxt.tx_rd_idx = s_r.tx_rd_idx + 1'b1;
         end
      end
      // ------------------------------------------------------------------
      // Frame control
      // ------------------------------------------------------------------
      if (s_r.frame_n) begin
         s_nxt.master = master_mode_i;
         s_nxt.par_en = parity_en_i;
      end
      if (active_w && !fault_w) begin
         if (s_r.master) begin
            open_w = s_nxt.shift_full || (!s_r.frame_n && !done_ev_w);
         end else begin
            open_w = !s_r.ss_s2;
         end
      end
      if (!open_w) begin
         s_nxt.frame_n = 1'b1;
         s_nxt.mid = 1'b0;
         if (!active_w || fault_w) begin
            s_nxt.shift_full = 1'b0;   // R17 R18
            s_nxt.in_flight = 1'b0;
         end
      end else begin
         s_nxt.frame_n = 1'b0;
         if (s_r.frame_n) begin
            s_nxt.mid = 1'b1;
         end
         if (s_r.frame_n || done_ev_w) begin
            s_nxt.in_flight = s_nxt.shift_full;
            if (!s_nxt.shift_full) begin
               // Hazard: a later move may rewrite this word while the link samples it
               s_nxt.tx_frame = s_nxt.last_rx;   // R12
            end
         end
      end
      if (tx_only_select_i) begin
         s_nxt.rx_full = 1'b0;   // R1
         s_nxt.ovr = 1'b0;
      end
      if (!port_enable_bit_i) begin
         s_nxt.tx_empty = 1'b1;   // R20
         s_nxt.tx_wr_idx = '0;
         s_nxt.tx_rd_idx = '0;
      end
      s_nxt.sclk_oe = port_enable_bit_i && !s_nxt.modf && master_mode_i;   // R16 R17
      s_nxt.mosi_oe = s_nxt.sclk_oe;
      s_nxt.sel_oe = s_nxt.sclk_oe;
      s_nxt.miso_oe = port_enable_bit_i && !s_nxt.modf && !master_mode_i && !s_r.ss_s2;   // R18
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         s_r <= sbfe_pkg::CORE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_data_o = s_r.rd_data;
   assign tx_empty_flag_o = s_r.tx_empty;   // R21
   assign rx_full_flag_o = s_r.rx_full;
   assign overrun_flag_o = s_r.ovr;
   assign parity_err_flag_o = s_r.par_err;
   assign mode_fault_flag_o = s_r.modf;
   assign tx_empty_irq_o = s_r.tx_irq;
   assign rx_full_irq_o = s_r.rx_irq;
   assign serial_clock_oe_o = s_r.sclk_oe;
   assign master_out_pin_o = tx_bit_w;
   assign master_out_oe_o = s_r.mosi_oe;
   assign master_in_pin_o = tx_bit_w;
   assign master_in_oe_o = s_r.miso_oe;
   assign slave_select_outs_n_o = {sbfe_pkg::SEL_W{s_r.frame_n}};
   assign slave_select_outs_oe_o = s_r.sel_oe;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   tx_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R1
      tx_only_select_i |=> !rx_full_flag_o && !overrun_flag_o) else $error("rx flag set in tx-only");
   tx_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R2
      wr_strobe_i && active_w && tx_empty_flag_o && frame_count_field_i == '0 && port_enable_bit_i
      |=> !tx_empty_flag_o && s_r.tx_mem[0] == $past(wr_data_i)) else $error("write not buffered");
   tx_move_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R3
      active_w && !s_r.tx_empty && !s_r.shift_full && s_r.tx_rd_idx == frame_count_field_i
      && port_enable_bit_i |=> tx_empty_flag_o && tx_empty_irq_o && s_r.shift_full)
      else $error("buffer not moved");
   shift_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R4
      s_r.in_flight && !done_ev_w && !fault_w && active_w |=> $stable(s_r.tx_frame))
      else $error("busy shifter overwritten");
   rx_store_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R5
      done_ev_w && !tx_only_select_i && !s_r.ovr && !s_r.rx_full && frame_count_field_i == '0
      |=> rx_full_flag_o && rx_full_irq_o && s_r.last_rx == $past(link_w.rx_word))
      else $error("receive not stored");
   ovr_free_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R7
      done_ev_w && s_r.in_flight && (s_r.rx_full || s_r.ovr) && !fault_w
      && s_r.tx_rd_idx == frame_count_field_i |=> !s_r.shift_full || tx_empty_irq_o)
      else $error("shifter kept after overrun");
   rd_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R8
      rd_strobe_i && s_r.rx_full && frame_count_field_i == '0 && !tx_only_select_i
      |=> rd_data_o == $past(s_r.rx_mem[0]) && !rx_full_flag_o) else $error("read did not clear");
   wr_drop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R11
      !s_r.tx_empty && port_enable_bit_i |=> $stable(s_r.tx_mem)) else $error("full buffer changed");
   resend_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R12
      s_r.frame_n && active_w && !fault_w && !s_r.master && !s_r.ss_s2 && !s_r.shift_full
      && s_r.tx_empty |=> s_r.tx_frame == $past(s_r.last_rx)) else $error("no resend");
   empty_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R13
      rd_strobe_i && !s_r.rx_full |=> rd_data_o == $past(s_r.last_rx) && !overrun_flag_o == !$past(s_r.ovr)
      || $past(done_ev_w) || $past(overrun_clr_i)) else $error("empty read wrong");
   ovr_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R14
      done_ev_w && !tx_only_select_i && s_r.rx_full && !rd_strobe_i
      |=> overrun_flag_o && $stable(s_r.rx_mem)) else $error("overrun missed");
   parity_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R15
      done_ev_w && !tx_only_select_i && !s_r.ovr && !s_r.rx_full && s_r.par_en && link_w.par_bad
      |=> parity_err_flag_o) else $error("parity error missed");
   mm_fault_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R16
      active_w && master_mode_i && multi_master_i && !s_r.ss_s2
      |=> mode_fault_flag_o && !serial_clock_oe_o && !master_out_oe_o && s_r.frame_n)
      else $error("multi-master fault missed");
   sl_abort_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R18
      active_w && !master_mode_i && s_r.mid && s_r.ss_s2 && !done_ev_w
      |=> mode_fault_flag_o && !master_in_oe_o && !s_r.shift_full) else $error("slave abort missed");
   frame_group_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R19
      wr_strobe_i && active_w && s_r.tx_empty && s_r.tx_wr_idx == '0 && frame_count_field_i == 2'h1
      |=> tx_empty_flag_o) else $error("flag changed early");
   enable_init_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R20
      !port_enable_bit_i |=> tx_empty_flag_o && s_r.tx_wr_idx == '0) else $error("tx buffer not reset");
   flag_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)   // R21
      overrun_flag_o && !overrun_clr_i && !tx_only_select_i |=> overrun_flag_o) else $error("overrun lost");

endmodule : sbfe_core

// ===== sbfe_peer.sv
// Behavioural link master driving select, serial clock and data toward the port
`timescale 1ns/10ps

module sbfe_peer (
   output logic link_clk_o,
   output logic ss_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   logic [15:0] got;

   // Clock stands still low between frames, select idles negated
   initial begin
      link_clk_o = 1'b0;
      ss_n_o = 1'b1;
      mosi_o = 1'b0;
      got = '0;
   end

   task automatic sel(input logic v);
      ss_n_o = v;
   endtask : sel

   // ------------------------------------------------------------------
   // Frames in one activation: word w+f in frame f, MSB first
   // ------------------------------------------------------------------
   task automatic frames(input logic [15:0] w, input int nfr, input int nb, input logic flip, input int stop);
      logic [16:0] v;
      ss_n_o = 1'b0;
      #47;
      for (int f = 0; f < nfr; f++) begin
         v = {w + 16'(f), (^(w + 16'(f))) ^ flip};
         for (int b = 0; b < nb; b++) begin
            if (b == stop) begin
               ss_n_o = 1'b1;
               mosi_o = ~mosi_o;
               return;
            end
            mosi_o = v[16-b];
            #40 link_clk_o = 1'b1;
            #20;
            if (b < 16) begin
               got = {got[14:0], miso_i};
            end
            #20 link_clk_o = 1'b0;
         end
      end
      // Released line must not keep showing the last bit
      mosi_o = ~mosi_o;
      #48 ss_n_o = 1'b1;
   endtask : frames

endmodule : sbfe_peer

// ===== sbfe_pkg.sv
// Shared constants, carriers and state types for the serial port buffer and flag logic
package sbfe_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int FRAME_MAX = 4;
   localparam int IDX_W = 2;
   localparam int CNT_W = 5;
   localparam int SEL_W = 3;

   // ------------------------------------------------------------------
   // Bit counter positions within one frame
   // ------------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_FIRST = CNT_W'(0);
   localparam logic [CNT_W-1:0] CNT_LAST_DATA = CNT_W'(WORD_W - 1);
   localparam logic [CNT_W-1:0] CNT_PARITY = CNT_W'(WORD_W);

   // ------------------------------------------------------------------
   // Carriers and state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic done_tog;
      logic par_bad;
      logic [WORD_W-1:0] rx_word;
   } sbfe_link_t;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [WORD_W-1:0] shreg;
      logic tx_par;
      logic tx_bit;
      logic done_tog;
      logic par_bad;
      logic [WORD_W-1:0] hold;
   } sbfe_lstate_t;

   typedef struct packed {
      logic ss_s1;
      logic ss_s2;
      logic done_s1;
      logic done_s2;
      logic done_seen;
      logic frame_n;
      logic mid;
      logic master;
      logic par_en;
      logic in_flight;
      logic shift_full;
      logic [WORD_W-1:0] tx_frame;
      logic [FRAME_MAX-1:0][WORD_W-1:0] tx_mem;
      logic [IDX_W-1:0] tx_wr_idx;
      logic [IDX_W-1:0] tx_rd_idx;
      logic tx_empty;
      logic [FRAME_MAX-1:0][WORD_W-1:0] rx_mem;
      logic [IDX_W-1:0] rx_wr_idx;
      logic [IDX_W-1:0] rx_rd_idx;
      logic rx_full;
      logic [WORD_W-1:0] last_rx;
      logic [WORD_W-1:0] rd_data;
      logic ovr;
      logic par_err;
      logic modf;
      logic tx_irq;
      logic rx_irq;
      logic sclk_oe;
      logic mosi_oe;
      logic miso_oe;
      logic sel_oe;
   } sbfe_cstate_t;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam sbfe_lstate_t LINK_RST = '0;
   localparam sbfe_cstate_t CORE_RST = '{ss_s1: 1'b1, ss_s2: 1'b1, frame_n: 1'b1, tx_empty: 1'b1, default: '0};

endpackage : sbfe_pkg

// ===== sbfe_tb.sv
// Self-checking bench for the serial port buffer, flag and error logic
`timescale 1ns/10ps

module testbench;
   typedef struct packed {
      logic [15:0] tx;
      logic [15:0] rx;
      logic par;
      logic flip;
   } sbfe_row_t;

   logic core_clk_i, rst_n_i, wr_s, rd_s, en, tx_only, mstr, mm, par_en, clr;
   logic [15:0] wr_d, rd_d;
   logic [1:0] fcnt;
   logic link_clk, ss_n, mosi_p, mosi_w, miso_w;
   logic txe, rxf, ovr, perr, mf, txi, rxi, sck_oe, mo, mo_oe, mi, mi_oe, so_oe;
   logic [2:0] so_n;
   int fails, cmp_count, rx_irqs;
   sbfe_row_t rows [3] = '{'{16'ha5c3, 16'h3c5a, 1'b0, 1'b0}, '{16'h0001, 16'h8000, 1'b1, 1'b0},
                          '{16'hffff, 16'h1234, 1'b1, 1'b1}};

   assign mosi_w = mo_oe ? mo : mosi_p;
   assign miso_w = mi_oe ? mi : ~mi;

   sbfe_core uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk), .wr_strobe_i(wr_s),
      .wr_data_i(wr_d), .rd_strobe_i(rd_s), .port_enable_bit_i(en), .tx_only_select_i(tx_only),
      .master_mode_i(mstr), .multi_master_i(mm), .parity_en_i(par_en), .frame_count_field_i(fcnt),
      .overrun_clr_i(clr), .parity_err_clr_i(clr), .mode_fault_clr_i(clr), .slave_select_in_n_i(ss_n),
      .master_out_pin_i(mosi_w), .master_in_pin_i(miso_w), .rd_data_o(rd_d), .tx_empty_flag_o(txe),
      .rx_full_flag_o(rxf), .overrun_flag_o(ovr), .parity_err_flag_o(perr), .mode_fault_flag_o(mf),
      .tx_empty_irq_o(txi), .rx_full_irq_o(rxi), .serial_clock_oe_o(sck_oe), .master_out_pin_o(mo),
      .master_out_oe_o(mo_oe), .master_in_pin_o(mi), .master_in_oe_o(mi_oe), .slave_select_outs_n_o(so_n),
      .slave_select_outs_oe_o(so_oe));

   sbfe_peer peer (.link_clk_o(link_clk), .ss_n_o(ss_n), .mosi_o(mosi_p), .miso_i(miso_w));

   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   // Receive interrupts are one-cycle pulses, so they are counted, not sampled
   always @(posedge core_clk_i) begin
      if (rxi === 1'b1) begin
         rx_irqs <= rx_irqs + 1;
      end
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask : cyc

   task automatic wr(input logic [15:0] d, output logic e1, output logic [1:0] e2);
      wr_d = d;
      wr_s = 1'b1;
      cyc(1);
      wr_s = 1'b0;
      e1 = txe;
      cyc(1);
      e2 = {txe, txi};
   endtask : wr

   task automatic rd(output logic [15:0] d);
      rd_s = 1'b1;
      cyc(1);
      rd_s = 1'b0;
      cyc(1);
      d = rd_d;
   endtask : rd

   task automatic fr(input logic [15:0] w, input int nfr, input int nb, input logic flip, input int stop);
      peer.frames(w, nfr, nb, flip, stop);
      cyc(8);
   endtask : fr

   task automatic clear_flags;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(1);
   endtask : clear_flags

   task automatic reset_chk;
      rst_n_i = 1'b0;
      cyc(5);
      rst_n_i = 1'b1;
      cyc(1);
      chk({txe, rxf, ovr, perr, mf, txi, rxi}, 16'h0040, "reset flags");
      chk({so_n, sck_oe, mo_oe, mi_oe, so_oe, mo, mi}, 16'h01c0, "reset outputs");
      chk(rd_d, 16'h0000, "reset read data");
      $display("test reset done");
   endtask : reset_chk

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   initial begin
      #200000;
      fails++;
      $display("watchdog expired");
      test_done();
   end

   // ------------------------------------------------------------------
   // Main sequence: table rows, then hand-written cases
   // ------------------------------------------------------------------
   initial begin
      logic e1;
      logic [1:0] e2;
      logic [15:0] d;
      {rst_n_i, wr_s, rd_s, tx_only, mstr, mm, par_en, clr} = '0;
      {en, wr_d, fcnt, fails, cmp_count, rx_irqs} = {1'b1, 18'h0, 32'd0, 32'd0, 32'd0};
      reset_chk();
      cyc(3);
      foreach (rows[i]) begin
         par_en = rows[i].par;
         wr(rows[i].tx, e1, e2);
         chk(e1, 1'b0, "write clears empty");
         chk(e2, 2'b11, "move sets empty with irq");
         fr(rows[i].rx, 1, 16 + int'(rows[i].par), rows[i].flip, 99);
         chk(peer.got, rows[i].tx, "shifted word");
         chk({rxf, perr}, {1'b1, rows[i].flip}, "receive flags");
         rd(d);
         chk(d, rows[i].rx, "read data");
         chk(rxf, 1'b0, "read clears full");
         clear_flags();
         $display("test row %0d done", i);
      end
      par_en = 1'b0;
      fcnt = 2'h1;
      wr(16'h1111, e1, e2);
      chk(e1, 1'b1, "one of two words");
      wr(16'h2222, e1, e2);
      chk(e1, 1'b0, "group written");
      fr(16'h4000, 2, 16, 1'b0, 99);
      rd(d);
      chk({rxf, d}, {1'b1, 16'h4000}, "first grouped word");
      rd(d);
      chk({rxf, txe, d}, {2'b01, 16'h4001}, "second grouped word");
      fcnt = 2'h0;
      $display("test frame group done");
      wr(16'hc001, e1, e2);
      wr(16'hc002, e1, e2);
      chk(e2, 2'b00, "pending while shifter busy");
      wr(16'hdead, e1, e2);
      chk({ovr, perr, mf}, 3'b000, "dropped write silent");
      fr(16'h0bad, 1, 16, 1'b0, 99);
      chk({txe, peer.got}, {1'b1, 16'hc001}, "frame end frees buffer");
      rd(d);
      fr(16'h0bee, 1, 16, 1'b0, 99);
      chk(peer.got, 16'hc002, "full buffer kept old word");
      rd(d);
      fr(16'h0cab, 1, 16, 1'b0, 99);
      chk({mf, peer.got}, {1'b0, 16'h0bee}, "resend last received");
      $display("test buffer handoff done");
      fr(16'h0dd0, 1, 16, 1'b0, 99);
      cyc(20);
      chk(ovr, 1'b1, "overrun held");
      rd(d);
      chk({rxf, d}, {1'b0, 16'h0cab}, "old word kept");
      rd(d);
      chk({rxf, perr, d}, {2'b00, 16'h0cab}, "read when empty");
      wr(16'hc003, e1, e2);
      wr(16'hc004, e1, e2);
      fr(16'h0ee0, 1, 16, 1'b0, 99);
      chk({txe, rxf}, 2'b10, "overrun frame frees shifter");
      clear_flags();
      $display("test overrun done");
      tx_only = 1'b1;
      fr(16'h0ff0, 1, 16, 1'b0, 99);
      chk(peer.got, 16'hc004, "transmit only word");
      fr(16'h0ff1, 1, 16, 1'b0, 99);
      chk({rxf, ovr, peer.got}, {2'b00, 16'h0cab}, "transmit only");
      tx_only = 1'b0;
      $display("test transmit only done");
      wr(16'hc005, e1, e2);
      wr(16'hc006, e1, e2);
      en = 1'b0;
      cyc(2);
      chk(txe, 1'b1, "disable empties buffer");
      en = 1'b1;
      cyc(2);
      fr(16'h1357, 1, 16, 1'b0, 5);
      chk({mf, mi_oe, rxf}, 3'b100, "slave abort");
      clear_flags();
      $display("test slave abort done");
      mstr = 1'b1;
      mm = 1'b1;
      cyc(4);
      peer.sel(1'b0);
      cyc(6);
      chk({mf, sck_oe, mo_oe, so_oe}, 4'h8, "multi-master fault");
      peer.sel(1'b1);
      cyc(4);
      chk(16'(rx_irqs), 16'h0007, "receive irq count");
      $display("test multi-master done");
      {mstr, mm} = 2'b00;
      reset_chk();
      test_done();
   end

endmodule : testbench
